// ### dwr_cfg.svh
// Purpose: Addresses, reset values, field positions and cycle counts
//          of the digital watchdog.
// Assumes: Included by the package and the watchdog module.
// Notes:   Definitions only.
`ifndef DWR_CFG_SVH
`define DWR_CFG_SVH

// Register byte addresses on the data-space bus
`define DWR_ADDR_CTRL 8'hd8
`define DWR_ADDR_STAT 8'hd9

// Control register reset value and field positions
`define DWR_CTRL_RST 8'hfe
`define DWR_C_BIT 0
`define DWR_SWR_BIT 1
`define DWR_T_TOP 7

// Physical counter: bits 0..5 countdown, bit 6 software reset
`define DWR_CNT_MSB 6
`define DWR_CNT_RST 7'h7f
`define DWR_CNT_TRIG 7'h40

// Program counter value fetched after every reset
`define DWR_VEC_ADDR 12'hffe

// Cycle counts
`define DWR_TICK_CYC 3072
`define DWR_HOLD_CYC 2048
`define DWR_CNT_MAX 4096

`endif

// ### dwr_pkg.sv
// Purpose: Types shared by the digital watchdog.
// Assumes: dwr_cfg.svh on the include path.
// Notes:   Whole module state lives in one packed struct.
`include "dwr_cfg.svh"

package dwr_pkg;

   typedef struct packed
   {
      logic pin1;
      logic pin2;
      logic nmi1;
      logic nmi2;
      logic rst_act;
      logic [11:0] hold;
      logic [11:0] pre;
      logic [6:0] cnt;
      logic en;
      logic stop;
      logic wait_m;
      logic nmi_mode;
      logic svc;
      logic stack_clr;
      logic wd_cause;
      logic ack;
      logic [7:0] dat;
      logic [11:0] vec;
      logic [12:0] hl;
   } dwr_state_t;

endpackage

// ### dwr_top.sv
// Purpose: Digital watchdog with internal reset stretcher and stop control.
// Assumes: Classic Wishbone, 8-bit data, one clock; pins are asynchronous.
// Notes:   Activation and stop-control options are static parameters.
//
// Behaviour
// - Missed reload forces internal reset, counter reinitialised
// - Watchdog reset restarts like pin reset
// - Any reset clears stack, fetches vector 0FFEh
// - Reset sets NMI mode; return clears, serves pending
// - Reset when downcounter steps from 40h to 3Fh
// - Software option: disabled until activation bit set
// - Once active, only reset disables watchdog
// - Disabled watchdog lets stop enter stop mode
// - Hardware option: always on, stop becomes wait
// - External control, NMI low: stop becomes wait
// - External control, NMI high: freeze and stop
// - Wake from stop resumes counting from frozen value
// - Register resets to 0FEh, longest period
// - Clearing software-reset bit resets immediately
// - Countdown bits map reversed onto counter
// - Falling counter bit 6 triggers reset
// - 64 periods, 3072 to 196608 cycles
// - Hardware option reads active; else 7-bit timer
// - At least 28 instructions before watchdog reset
// - Internal reset held 2048 cycles after release
`timescale 1ns/1ps
`include "dwr_cfg.svh"

module dwr_top
   import dwr_pkg::*;
#(
   parameter bit HW_ACT = 1'b0,
   parameter bit EXT_STOP = 1'b0,
   parameter int TICK_CYC = `DWR_TICK_CYC,
   parameter int HOLD_CYC = `DWR_HOLD_CYC
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [7:0] dat_i,
   input wire logic sel_i,
   output logic [7:0] dat_o,
   output logic ack_o,
   // Device pins
   input wire logic ext_rst_n_i,
   input wire logic nmi_i,
   // Core handshake
   input wire logic stop_req_i,
   input wire logic wake_i,
   input wire logic irq_ret_i,
   input wire logic irq_pend_i,
   // Core control
   output logic core_rst_o,
   output logic stack_clr_o,
   output logic [11:0] vec_addr_o,
   output logic nmi_mode_o,
   output logic irq_svc_o,
   output logic stop_mode_o,
   output logic wait_mode_o,
   output logic wdg_en_o
);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration checks and constants

   if (TICK_CYC < 1 || TICK_CYC > `DWR_CNT_MAX)
   begin : g_bad_tick
      $error("TICK_CYC out of range");
   end
   if (HOLD_CYC < 1 || HOLD_CYC > `DWR_CNT_MAX)
   begin : g_bad_hold
      $error("HOLD_CYC out of range");
   end

   localparam logic [11:0] TICK_RLD = 12'(TICK_CYC - 1);
   localparam logic [11:0] HOLD_RLD = 12'(HOLD_CYC - 1);

   localparam dwr_state_t RST_S = '{
      pin1: 1'b1, pin2: 1'b1, nmi1: 1'b0, nmi2: 1'b0,
      rst_act: 1'b1, hold: HOLD_RLD, pre: TICK_RLD,
      cnt: `DWR_CNT_RST, en: 1'b0, stop: 1'b0, wait_m: 1'b0,
      nmi_mode: 1'b1, svc: 1'b0, stack_clr: 1'b0, wd_cause: 1'b0,
      ack: 1'b0, dat: 8'h00, vec: `DWR_VEC_ADDR, hl: 13'h0000};

   dwr_state_t s_q;
   dwr_state_t s_d;

   logic req_w;
   logic wr_ctrl_w;
   logic en_w;
   logic tick_w;
   logic trig_sw_w;
   logic trig_wd_w;
   logic [6:0] wr_cnt_w;
   logic [7:0] rd_ctrl_w;

   ////////////////////////////////////////////////////////////////////////
   // Register bit order versus physical counter

   for (genvar i = 0; i < `DWR_CNT_MSB; i++)
   begin : g_map
      assign wr_cnt_w[i] = dat_i[`DWR_T_TOP - i];
      assign rd_ctrl_w[`DWR_T_TOP - i] = s_q.cnt[i];
   end
   assign wr_cnt_w[`DWR_CNT_MSB] = dat_i[`DWR_SWR_BIT];
   assign rd_ctrl_w[`DWR_SWR_BIT] = s_q.cnt[`DWR_CNT_MSB];
   assign rd_ctrl_w[`DWR_C_BIT] = en_w;

   ////////////////////////////////////////////////////////////////////////
   // Event decode

   assign req_w = cyc_i & stb_i & ~s_q.ack;
   // Writes during the internal reset are dropped: the register is held
   assign wr_ctrl_w = req_w & we_i & sel_i & ~s_q.rst_act
                    & (adr_i == `DWR_ADDR_CTRL);
   assign en_w = HW_ACT | s_q.en;
   // Prescaler stands still while stopped, so the count is frozen
   assign tick_w = (s_q.pre == 12'h000) & ~s_q.stop & ~s_q.rst_act;
   assign trig_sw_w = wr_ctrl_w & ~dat_i[`DWR_SWR_BIT]
                    & s_q.cnt[`DWR_CNT_MSB];
   // Bit 6 falls only on the step from 40h; a write in the same cycle wins
   assign trig_wd_w = en_w & tick_w & ~wr_ctrl_w
                    & (s_q.cnt == `DWR_CNT_TRIG);

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      s_d = s_q;
      s_d.pin1 = ext_rst_n_i;
      s_d.pin2 = s_q.pin1;
      s_d.nmi1 = nmi_i;
      s_d.nmi2 = s_q.nmi1;
      s_d.ack = req_w;
      s_d.svc = 1'b0;
      s_d.stack_clr = 1'b0;
      s_d.vec = `DWR_VEC_ADDR;
      s_d.hl = (s_q.rst_act & s_q.pin2) ? s_q.hl + 13'h0001 : 13'h0000;
      if (req_w & ~we_i)
      begin
         case (adr_i)
            `DWR_ADDR_CTRL: s_d.dat = rd_ctrl_w;
            `DWR_ADDR_STAT: s_d.dat = {4'h0, s_q.wd_cause, en_w,
                                       s_q.wait_m, s_q.stop};
            default: s_d.dat = 8'h00;
         endcase
      end
      if (s_q.rst_act)
      begin
         // Register and modes sit at their reset values throughout
         s_d.cnt = `DWR_CNT_RST;
         s_d.en = 1'b0;
         s_d.pre = TICK_RLD;
         s_d.stop = 1'b0;
         s_d.wait_m = 1'b0;
         s_d.nmi_mode = 1'b1;
         if (!s_q.pin2)
         begin
            s_d.hold = HOLD_RLD;
         end
         else if (s_q.hold == 12'h000)
         begin
            s_d.rst_act = 1'b0;
            s_d.stack_clr = 1'b1;
         end
         else
         begin
            s_d.hold = s_q.hold - 12'h001;
         end
      end
      else if (trig_sw_w | trig_wd_w | ~s_q.pin2)
      begin
         // Same stretched sequence whatever the cause
         s_d.rst_act = 1'b1;
         s_d.hold = HOLD_RLD;
         s_d.wd_cause = trig_sw_w | trig_wd_w;
      end
      else
      begin
         // A reload restarts the prescaler so a load of n gives n+1 ticks
         if (wr_ctrl_w | tick_w)
         begin
            s_d.pre = TICK_RLD;
         end
         else if (!s_q.stop)
         begin
            s_d.pre = s_q.pre - 12'h001;
         end
         if (wr_ctrl_w)
         begin
            s_d.cnt = wr_cnt_w;
            s_d.en = s_q.en | dat_i[`DWR_C_BIT];
         end
         else if (tick_w)
         begin
            // With the watchdog off this is a free 7-bit timer
            s_d.cnt = s_q.cnt - 7'h01;
         end
         if (stop_req_i & ~s_q.stop & ~s_q.wait_m)
         begin
            if (!en_w)
            begin
               s_d.stop = 1'b1;
            end
            else if (EXT_STOP & s_q.nmi2)
            begin
               s_d.stop = 1'b1;
            end
            else
            begin
               s_d.wait_m = 1'b1;
            end
         end
         if (wake_i)
         begin
            s_d.stop = 1'b0;
            s_d.wait_m = 1'b0;
         end
         if (irq_ret_i)
         begin
            s_d.nmi_mode = 1'b0;
            s_d.svc = irq_pend_i;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_q <= RST_S;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign dat_o = s_q.dat;
   assign ack_o = s_q.ack;
   assign core_rst_o = s_q.rst_act;
   assign stack_clr_o = s_q.stack_clr;
   assign vec_addr_o = s_q.vec;
   assign nmi_mode_o = s_q.nmi_mode;
   assign irq_svc_o = s_q.svc;
   assign stop_mode_o = s_q.stop;
   assign wait_mode_o = s_q.wait_m;
   assign wdg_en_o = s_q.en;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_swrst_clear: assert property (
      trig_sw_w && !s_q.rst_act |=> core_rst_o && s_q.wd_cause)
      else $error("Clearing software reset bit did not reset");

   a_underflow_reset: assert property (
      en_w && tick_w && !wr_ctrl_w && s_q.cnt == `DWR_CNT_TRIG
      && !s_q.rst_act |=> core_rst_o)
      else $error("Counter reached end without reset");

   a_timer_no_reset: assert property (
      !en_w && s_q.pin2 && !s_q.rst_act && !trig_sw_w |=> !core_rst_o)
      else $error("Disabled watchdog forced a reset");

   a_reset_reload: assert property (
      core_rst_o ##1 core_rst_o |-> s_q.cnt == `DWR_CNT_RST && !s_q.en)
      else $error("Register not at reset value");

   a_hold_length: assert property (
      $fell(core_rst_o) |-> $past(s_q.hl) == 13'(HOLD_CYC - 1))
      else $error("Internal reset stretch wrong length");

   a_enable_sticky: assert property (
      s_q.en && !core_rst_o |=> s_q.en || core_rst_o)
      else $error("Watchdog was disabled without reset");

   a_stop_freeze: assert property (
      stop_mode_o && !core_rst_o |=> $stable(s_q.cnt) && $stable(s_q.pre))
      else $error("Counter moved in stop mode");

   a_stop_as_wait: assert property (
      stop_req_i && en_w && !(EXT_STOP && s_q.nmi2) && !stop_mode_o
      && !wait_mode_o && !wake_i && s_q.pin2 && !core_rst_o
      && !trig_sw_w && !trig_wd_w |=> wait_mode_o && !stop_mode_o)
      else $error("Stop not turned into wait");

   a_vec_fetch: assert property (
      $fell(core_rst_o) |-> stack_clr_o ##1 !stack_clr_o)
      else $error("No stack clear at reset release");

   a_nmi_after_rst: assert property (
      $fell(core_rst_o) |-> nmi_mode_o throughout (##[0:2] 1'b1))
      else $error("NMI mode not set after reset");

   a_ctrl_read_map: assert property (
      req_w && !we_i && adr_i == `DWR_ADDR_CTRL
      |=> ack_o && dat_o[`DWR_T_TOP] == $past(s_q.cnt[0]))
      else $error("Control read bit order wrong");

   a_hw_read_active: assert property (
      HW_ACT && req_w && !we_i && adr_i == `DWR_ADDR_CTRL
      |=> dat_o[`DWR_C_BIT])
      else $error("Hardware activation bit not read as one");

   a_ext_stop_entry: assert property (
      EXT_STOP && stop_req_i && en_w && s_q.nmi2 && !stop_mode_o
      && !wait_mode_o && !wake_i && s_q.pin2 && !core_rst_o
      && !trig_sw_w && !trig_wd_w |=> stop_mode_o && !wait_mode_o)
      else $error("External stop control did not stop");

   a_wake_resume: assert property (
      stop_mode_o && wake_i && !core_rst_o && s_q.pin2 && !wr_ctrl_w
      |=> !stop_mode_o && $stable(s_q.cnt))
      else $error("Wake did not resume from frozen count");

   a_tick_step: assert property (
      tick_w && !wr_ctrl_w && !trig_wd_w && s_q.pin2
      |=> s_q.cnt == $past(s_q.cnt) - 7'h01 && s_q.pre == TICK_RLD)
      else $error("Counter step or prescaler reload wrong");

   c_wdg_reset: cover property (trig_wd_w);
   c_sw_reset: cover property (trig_sw_w);
   c_stop_wake: cover property (stop_mode_o ##1 wake_i);
   c_ret_svc: cover property (irq_svc_o);
   c_ext_stop: cover property (EXT_STOP && stop_mode_o && en_w);

endmodule // dwr_top

// ### tb_dwr_top.sv
// Purpose: Self-checking bench for the digital watchdog.
// Assumes: Main instance uses software activation; the second one has
//          hardware activation with external stop control.
// Notes:   Prescaler and hold counts shortened to keep the run brief.
`timescale 1ns/1ps
module tb_dwr_top;
   localparam int TK = 4;
   localparam int HD = 8;
   logic clk, rst, cyc, stb, we, sel, ack, ext_rst_n, nmi, stop_req;
   logic wake, irq_ret, irq_pend, core_rst, stack_clr, nmi_mode, irq_svc;
   logic stop_m, wait_m, wdg_en;
   logic [7:0] adr, wdat, rdat, q;
   logic [11:0] vec;
   logic rst_h, hw, h_ack, h_core_rst, h_stop_m, h_wait_m;
   logic [7:0] h_rdat;
   int n_mismatch, n_compared, k;

   dwr_top #(.HW_ACT(1'b0), .EXT_STOP(1'b0), .TICK_CYC(TK), .HOLD_CYC(HD))
   i_dwr_top (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(rdat),
      .ack_o(ack), .ext_rst_n_i(ext_rst_n), .nmi_i(nmi),
      .stop_req_i(stop_req), .wake_i(wake), .irq_ret_i(irq_ret),
      .irq_pend_i(irq_pend), .core_rst_o(core_rst),
      .stack_clr_o(stack_clr), .vec_addr_o(vec), .nmi_mode_o(nmi_mode),
      .irq_svc_o(irq_svc), .stop_mode_o(stop_m), .wait_mode_o(wait_m),
      .wdg_en_o(wdg_en));

   // Held in reset until its own scenario; shares the bus and core pins
   dwr_top #(.HW_ACT(1'b1), .EXT_STOP(1'b1), .TICK_CYC(TK), .HOLD_CYC(HD))
   i_dwr_top_hw (.clk_i(clk), .rst_i(rst_h), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(h_rdat),
      .ack_o(h_ack), .ext_rst_n_i(ext_rst_n), .nmi_i(nmi),
      .stop_req_i(stop_req), .wake_i(wake), .irq_ret_i(irq_ret),
      .irq_pend_i(irq_pend), .core_rst_o(h_core_rst), .stack_clr_o(),
      .vec_addr_o(), .nmi_mode_o(), .irq_svc_o(), .stop_mode_o(h_stop_m),
      .wait_mode_o(h_wait_m), .wdg_en_o());

   ////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One classic cycle; returns one edge after ack so cyc/stb idle a cycle
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] r);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      sel <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while ((hw ? h_ack : ack) !== 1'b1 && n < 20);
      r = hw ? h_rdat : rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      sel <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
      if (n >= 20)
         n_mismatch++;
   endtask

   task automatic wait_rst(input logic lvl, output int n);
      n = 0;
      while ((hw ? h_core_rst : core_rst) !== lvl && n < 5000)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 5000)
         n_mismatch++;
   endtask

   ////////////////////////////////////////////////////////////////////
   task automatic t_boot();
      wait_rst(1'b0, k);
      chk(12'(k >= HD - 1 && k <= HD + 1), 12'h1);
      chk(12'(stack_clr), 12'h1);
      chk(vec, 12'hffe);
      chk(12'(nmi_mode), 12'h1);
      wb(1'b0, 8'hd8, 8'h00, q);
      chk(12'(q), 12'h0fe);
      chk(12'(wdg_en), 12'h0);
      wb(1'b0, 8'h20, 8'h00, q);
      chk(12'(q), 12'h000);
   endtask

   task automatic t_ret();
      irq_ret <= 1'b1;
      irq_pend <= 1'b1;
      @(posedge clk);
      irq_ret <= 1'b0;
      irq_pend <= 1'b0;
      @(posedge clk);
      chk(12'(nmi_mode), 12'h0);
      chk(12'(irq_svc), 12'h1);
      @(posedge clk);
      chk(12'(irq_svc), 12'h0);
   endtask

   // Disabled watchdog: stop is honoured, free timer never resets
   task automatic t_idle();
      stop_req <= 1'b1;
      @(posedge clk);
      stop_req <= 1'b0;
      @(posedge clk);
      chk(12'({stop_m, wait_m}), 12'h2);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      @(posedge clk);
      chk(12'(stop_m), 12'h0);
      wb(1'b1, 8'hd8, 8'h82, q);
      repeat (40) @(posedge clk);
      chk(12'(core_rst), 12'h0);
   endtask

   // Load count one (register bit 7), activate, then miss the reload
   task automatic t_wdg();
      wb(1'b1, 8'hd8, 8'h83, q);
      chk(12'(wdg_en), 12'h1);
      wb(1'b1, 8'hd8, 8'h82, q);
      chk(12'(wdg_en), 12'h1);
      stop_req <= 1'b1;
      @(posedge clk);
      stop_req <= 1'b0;
      @(posedge clk);
      chk(12'({stop_m, wait_m}), 12'h1);
      wait_rst(1'b1, k);
      chk(12'(k >= 1 && k <= 2 * TK), 12'h1);
      wait_rst(1'b0, k);
      chk(12'(k >= HD - 1 && k <= HD + 1), 12'h1);
      wb(1'b0, 8'hd8, 8'h00, q);
      chk(12'(q), 12'h0fe);
      wb(1'b0, 8'hd9, 8'h00, q);
      chk(12'(q[3:0]), 12'h8);
   endtask

   task automatic t_swrst();
      wb(1'b1, 8'hd8, 8'hfc, q);
      wait_rst(1'b1, k);
      chk(12'(k <= 1), 12'h1);
      wait_rst(1'b0, k);
      ext_rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      chk(12'(core_rst), 12'h1);
      ext_rst_n <= 1'b1;
      wait_rst(1'b0, k);
      wb(1'b0, 8'hd9, 8'h00, q);
      chk(12'(q[3]), 12'h0);
   endtask

   // Hardware activation: stop is wait while NMI low, freezes while high
   task automatic t_hw();
      hw = 1'b1;
      rst_h <= 1'b0;
      wait_rst(1'b0, k);
      chk(12'(k >= HD - 1 && k <= HD + 1), 12'h1);
      wb(1'b0, 8'hd8, 8'h00, q);
      chk(12'(q), 12'h0ff);
      stop_req <= 1'b1;
      @(posedge clk);
      stop_req <= 1'b0;
      @(posedge clk);
      chk(12'({h_stop_m, h_wait_m}), 12'h1);
      wake <= 1'b1;
      nmi <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      repeat (2) @(posedge clk);
      wb(1'b1, 8'hd8, 8'h82, q);
      stop_req <= 1'b1;
      @(posedge clk);
      stop_req <= 1'b0;
      @(posedge clk);
      chk(12'({h_stop_m, h_wait_m}), 12'h2);
      repeat (20) @(posedge clk);
      chk(12'(h_core_rst), 12'h0);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      wait_rst(1'b1, k);
      chk(12'(k >= 1 && k <= 2 * TK), 12'h1);
   endtask

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      #200000;
      n_mismatch++;
      test_done();
   end

   initial
   begin
      {cyc, stb, we, sel, stop_req, wake, irq_ret, irq_pend} = '0;
      {adr, wdat} = '0;
      rst = 1'b1;
      rst_h = 1'b1;
      hw = 1'b0;
      ext_rst_n = 1'b1;
      nmi = 1'b0;
      n_mismatch = 0;
      n_compared = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_boot();
      t_ret();
      t_idle();
      t_wdg();
      t_swrst();
      t_hw();
      test_done();
   end
endmodule // tb_dwr_top
